// File: rtl/chs_map.vh
`ifndef CHS_MAP_VH
`define CHS_MAP_VH

// Register byte offsets
`define CHS_OFF_CTRL        8'h00
`define CHS_OFF_STAT        8'h04
`define CHS_OFF_IRQ_STAT    8'h08
`define CHS_OFF_IRQ_MASK    8'h0C
`define CHS_OFF_VECTOR      8'h10

// Control fields
`define CHS_CTRL_HALT       0
`define CHS_CTRL_RESUME     1
`define CHS_CTRL_DBG_WAKE   2

// Status fields
`define CHS_STAT_HALTED     0
`define CHS_STAT_ERROR      1
`define CHS_STAT_SLEEP      2
`define CHS_STAT_HALT_REQ   3
`define CHS_STAT_DBG_WAKEUP 4
`define CHS_STAT_PENDING    5

// Interrupt event fields
`define CHS_EV_HALTED       0
`define CHS_EV_ERROR        1
`define CHS_EV_SLEEP        2
`define CHS_EV_WAKE         3
`define CHS_EV_W            4

// Reset values
`define CHS_RST_MASK        4'h0
`define CHS_RST_DBG_WAKE    1'b0

// Response codes
`define CHS_RESP_OKAY       2'h0
`define CHS_RESP_SLVERR     2'h2

// Synchroniser depth
`define CHS_SYNC_STAGES     2

`endif

// File: rtl/chs_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "chs_map.vh"

module chs_sync #(
    parameter WIDTH = 1
) (
    input  wire             aclk,    // Core clock
    input  wire             aresetn, // Sync reset, active low
    input  wire [WIDTH-1:0] d_in,    // Asynchronous inputs
    output wire [WIDTH-1:0] q_out    // Synchronised outputs
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // First stage feeds only the second stage
    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule
`default_nettype wire

// File: rtl/chs_core_halt_sleep_control.v
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "chs_map.vh"

module chs_core_halt_sleep_control #(
    parameter DEBUG_ENABLED  = 1,
    parameter FAULT_TOLERANT = 1,
    parameter INTERRUPT_MODE = 2
) (
    input  wire        aclk,                  // Core clock, 25 MHz
    input  wire        aresetn,               // Sync reset, active low
    input  wire [7:0]  s_axi_awaddr,          // Write address
    input  wire        s_axi_awvalid,         // Write address valid
    output wire        s_axi_awready,         // Write address ready
    input  wire [31:0] s_axi_wdata,           // Write data
    input  wire [3:0]  s_axi_wstrb,           // Write strobes
    input  wire        s_axi_wvalid,          // Write data valid
    output wire        s_axi_wready,          // Write data ready
    output wire [1:0]  s_axi_bresp,           // Write response
    output wire        s_axi_bvalid,          // Write response valid
    input  wire        s_axi_bready,          // Write response ready
    input  wire [7:0]  s_axi_araddr,          // Read address
    input  wire        s_axi_arvalid,         // Read address valid
    output wire        s_axi_arready,         // Read address ready
    output wire [31:0] s_axi_rdata,           // Read data
    output wire [1:0]  s_axi_rresp,           // Read response
    output wire        s_axi_rvalid,          // Read data valid
    input  wire        s_axi_rready,          // Read data ready
    input  wire        core_reset,            // Core reset pin, active high
    input  wire        core_reset_alt,        // Alternate core reset pin, active high
    input  wire        dbg_stop,              // Debug halt request pin
    input  wire [1:0]  wakeup,                // Wake pins
    input  wire        missed_exception,      // Pulse from core, exception missed
    input  wire        sleep_exec,            // Pulse from core, sleep instruction done
    input  wire        ext_access_busy,       // Core has external accesses outstanding
    input  wire        pipe_stopped,          // Core pipeline is idle
    input  wire        int_taken,             // Pulse from core, interrupt taken
    input  wire [31:0] interrupt_address,     // Interrupt vector from controller
    output wire        halt_req,              // Stop request to pipeline
    output wire        fetch_hold,            // Hold fetch for sleep entry
    output wire        fetch_resume,          // One-cycle pulse, fetch resumes
    output wire        pipeline_halted,       // Pipeline is halted
    output wire        missed_exception_halt, // Halted by missed exception
    output wire        sleep,                 // Core is sleeping
    output wire        dbg_wakeup,            // Debug wake request to wake logic
    output wire        interrupt_ack,         // Interrupt acknowledge pulse
    output wire [31:0] int_vector,            // Latched interrupt vector
    output wire        irq                    // Level interrupt
);

    localparam ST_RUN   = 2'b00;
    localparam ST_PEND  = 2'b01;
    localparam ST_SLEEP = 2'b10;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    wire [4:0] pins_s;
    wire       rst_s;
    wire       rst_alt_s;
    wire       stop_s;
    wire [1:0] wake_s;

    chs_sync #(
        .WIDTH (5)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d_in    ({wakeup, dbg_stop, core_reset_alt, core_reset}),
        .q_out   (pins_s)
    );

    assign rst_s     = pins_s[0];
    assign rst_alt_s = pins_s[1];
    assign stop_s    = pins_s[2];
    assign wake_s    = pins_s[4:3];

    wire core_rst = rst_s | rst_alt_s;

    reg  stop_d_r;
    wire stop_rise = stop_s & ~stop_d_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            stop_d_r <= 1'b0;
        end else begin
            stop_d_r <= stop_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave

    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a == `CHS_OFF_CTRL) || (a == `CHS_OFF_STAT) ||
                      (a == `CHS_OFF_IRQ_STAT) || (a == `CHS_OFF_IRQ_MASK) ||
                      (a == `CHS_OFF_VECTOR);
        end
    endfunction

    reg        aw_full_r;
    reg [7:0]  aw_addr_r;
    reg        w_full_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    reg        bvalid_r;
    reg [1:0]  bresp_r;
    reg        rvalid_r;
    reg [1:0]  rresp_r;
    reg [31:0] rdata_r;

    assign s_axi_awready = ~aw_full_r & ~bvalid_r;
    assign s_axi_wready  = ~w_full_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    wire do_write = aw_full_r & w_full_r & ~bvalid_r;
    wire wr_lane0 = do_write & w_strb_r[0];
    wire wr_ctrl  = wr_lane0 & (aw_addr_r == `CHS_OFF_CTRL);
    wire wr_ist   = wr_lane0 & (aw_addr_r == `CHS_OFF_IRQ_STAT);
    wire wr_mask  = wr_lane0 & (aw_addr_r == `CHS_OFF_IRQ_MASK);
    wire do_read  = s_axi_arvalid & ~rvalid_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_full_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CHS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_r <= 1'b0;
                w_full_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= addr_ok(aw_addr_r) ? `CHS_RESP_OKAY : `CHS_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Halt and error

    reg halt_r;
    reg halted_r;
    reg err_r;
    reg dbg_wake_en_r;

    wire halt_cmd   = wr_ctrl & w_data_r[`CHS_CTRL_HALT];
    wire resume_cmd = wr_ctrl & w_data_r[`CHS_CTRL_RESUME];
    wire err_set    = (FAULT_TOLERANT == 1) & missed_exception;
    wire stop_evt   = (DEBUG_ENABLED == 1) & stop_rise;
    wire halt_set   = stop_evt | halt_cmd | err_set;

    always @(posedge aclk) begin
        if (!aresetn || core_rst) begin
            halt_r   <= 1'b0;
            halted_r <= 1'b0;
            err_r    <= 1'b0;
        end else begin
            if (halt_set) begin
                halt_r <= 1'b1;
            end else if (resume_cmd && !err_r) begin
                halt_r <= 1'b0;
            end
            if (err_set) begin
                err_r <= 1'b1;
            end
            halted_r <= halt_r & pipe_stopped;
        end
    end

    assign halt_req              = halt_r;
    assign pipeline_halted       = halted_r;
    assign missed_exception_halt = err_r;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep handshake

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg       sleep_r;
    reg       resume_r;
    reg       dbg_wakeup_r;

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (sleep_exec) begin
                    state_nxt = ST_PEND;
                end
            end
            ST_PEND: begin
                if (!ext_access_busy && pipe_stopped) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (|wake_s) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    wire wake_evt = (state_r == ST_SLEEP) && (state_nxt == ST_RUN);

    // Sleep and resume change on the same edge, so no cycle sleeps while fetching
    always @(posedge aclk) begin
        if (!aresetn || core_rst) begin
            state_r      <= ST_RUN;
            sleep_r      <= 1'b0;
            resume_r     <= 1'b0;
            dbg_wakeup_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            sleep_r      <= (state_nxt == ST_SLEEP);
            resume_r     <= wake_evt;
            dbg_wakeup_r <= dbg_wake_en_r & (state_nxt == ST_SLEEP);
        end
    end

    assign fetch_hold   = (state_r != ST_RUN);
    assign fetch_resume = resume_r;
    assign sleep        = sleep_r;
    assign dbg_wakeup   = dbg_wakeup_r;

    ////////////////////////////////////////////////////////////////////////////
    // Low-latency interrupt vector

    reg        ack_r;
    reg [31:0] vec_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ack_r <= 1'b0;
            vec_r <= 32'h0000_0000;
        end else begin
            ack_r <= (INTERRUPT_MODE == 2) & int_taken;
            if (INTERRUPT_MODE == 2 && int_taken) begin
                vec_r <= interrupt_address;
            end
        end
    end

    assign interrupt_ack = ack_r;
    assign int_vector    = vec_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control, interrupt status and mask

    reg  [`CHS_EV_W-1:0] ist_r;
    reg  [`CHS_EV_W-1:0] mask_r;
    reg                  halted_d_r;
    reg                  sleep_d_r;
    wire [`CHS_EV_W-1:0] ev;

    assign ev[`CHS_EV_HALTED] = halted_r & ~halted_d_r;
    assign ev[`CHS_EV_ERROR]  = err_set;
    assign ev[`CHS_EV_SLEEP]  = sleep_r & ~sleep_d_r;
    assign ev[`CHS_EV_WAKE]   = wake_evt;

    wire [`CHS_EV_W-1:0] ist_clr = wr_ist ? w_data_r[`CHS_EV_W-1:0] : {`CHS_EV_W{1'b0}};

    // Set beats clear so a coincident event is kept
    always @(posedge aclk) begin
        if (!aresetn) begin
            ist_r         <= {`CHS_EV_W{1'b0}};
            mask_r        <= `CHS_RST_MASK;
            dbg_wake_en_r <= `CHS_RST_DBG_WAKE;
            halted_d_r    <= 1'b0;
            sleep_d_r     <= 1'b0;
        end else begin
            ist_r      <= (ist_r & ~ist_clr) | ev;
            halted_d_r <= halted_r;
            sleep_d_r  <= sleep_r;
            if (wr_mask) begin
                mask_r <= w_data_r[`CHS_EV_W-1:0];
            end
            if (wr_ctrl) begin
                dbg_wake_en_r <= w_data_r[`CHS_CTRL_DBG_WAKE];
            end else if (wake_evt) begin
                dbg_wake_en_r <= 1'b0;
            end
        end
    end

    assign irq = |(ist_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `CHS_OFF_CTRL: begin
                rd_mux[`CHS_CTRL_DBG_WAKE] = dbg_wake_en_r;
            end
            `CHS_OFF_STAT: begin
                rd_mux[`CHS_STAT_HALTED]     = halted_r;
                rd_mux[`CHS_STAT_ERROR]      = err_r;
                rd_mux[`CHS_STAT_SLEEP]      = sleep_r;
                rd_mux[`CHS_STAT_HALT_REQ]   = halt_r;
                rd_mux[`CHS_STAT_DBG_WAKEUP] = dbg_wakeup_r;
                rd_mux[`CHS_STAT_PENDING]    = (state_r == ST_PEND);
            end
            `CHS_OFF_IRQ_STAT: begin
                rd_mux[`CHS_EV_W-1:0] = ist_r;
            end
            `CHS_OFF_IRQ_MASK: begin
                rd_mux[`CHS_EV_W-1:0] = mask_r;
            end
            `CHS_OFF_VECTOR: begin
                rd_mux = vec_r;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r  <= `CHS_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (do_read) begin
            rvalid_r <= 1'b1;
            rresp_r  <= addr_ok(s_axi_araddr) ? `CHS_RESP_OKAY : `CHS_RESP_SLVERR;
            rdata_r  <= rd_mux;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: sim/chs_partner.sv
`timescale 1ns/1ps
`default_nettype none
module chs_partner (
    input  wire       aclk,             // Core clock
    input  wire       stop_go,          // Bench asks for a halt
    input  wire       kick,             // Bench asks for a wake
    input  wire [1:0] wake_val,         // Wake pattern to drive
    input  wire       dbg_wakeup,       // Debug wake request
    output reg        dbg_stop = 1'b0,  // Halt request pin
    output reg  [1:0] wakeup   = 2'h0   // Wake pins
);
    reg [1:0] hold_r = 2'h0;
    ////////////////////////////////////////////////////////////////
    // Two-cycle pulse, so the edge survives the synchroniser
    always @(posedge aclk) begin
        hold_r   <= stop_go ? 2'h2 : (hold_r != 2'h0 ? hold_r - 2'h1 : 2'h0);
        dbg_stop <= stop_go || hold_r > 2'h1;
        wakeup   <= (dbg_wakeup || kick) ? wake_val : 2'h0;
    end
endmodule
`default_nettype wire

// File: sim/chs_core_halt_sleep_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module chs_props #(
    parameter DEBUG_ENABLED  = 1,
    parameter FAULT_TOLERANT = 1,
    parameter INTERRUPT_MODE = 2
) (
    input wire        aclk,                  // Clock
    input wire        aresetn,               // Reset
    input wire        core_reset,            // Core reset
    input wire        core_reset_alt,        // Core reset, alternate
    input wire        dbg_stop,              // Halt pin
    input wire [1:0]  wakeup,                // Wake pins
    input wire        missed_exception,      // Missed exception
    input wire        ext_access_busy,       // Accesses open
    input wire        pipe_stopped,          // Pipe idle
    input wire        int_taken,             // Interrupt taken
    input wire [31:0] interrupt_address,     // Vector in
    input wire        halt_req,              // Stop request
    input wire        fetch_hold,            // Fetch held
    input wire        fetch_resume,          // Fetch resumes
    input wire        pipeline_halted,       // Halted
    input wire        missed_exception_halt, // Error halt
    input wire        sleep,                 // Sleeping
    input wire        interrupt_ack,         // Acknowledge
    input wire [31:0] int_vector             // Vector out
);
    reg [2:0] calm_r;
    // Core reset effects lag the pins, so quiet periods are tracked
    always @(posedge aclk) begin
        if (!aresetn || core_reset || core_reset_alt) calm_r <= 3'h0;
        else if (calm_r != 3'h7) calm_r <= calm_r + 3'h1;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_stop_halts: assert property (DEBUG_ENABLED == 1 && calm_r == 3'h7 && $rose(dbg_stop)
        |-> ##[2:5] halt_req) else $error("Stop pin did not raise halt");
    chk_halted_follows: assert property (calm_r == 3'h7 && halt_req && pipe_stopped
        |=> pipeline_halted) else $error("Halted output missing");
    chk_miss_halts: assert property (FAULT_TOLERANT == 1 && calm_r == 3'h7 && missed_exception
        |=> missed_exception_halt && halt_req) else $error("Missed exception not halted");
    chk_sleep_entry: assert property ($rose(sleep)
        |-> $past(fetch_hold && pipe_stopped && !ext_access_busy)) else $error("Early sleep");
    chk_wake_ends: assert property (calm_r == 3'h7 && sleep && wakeup != 2'h0
        |-> ##[1:4] !sleep) else $error("Wake ignored");
    chk_resume_pulse: assert property (calm_r == 3'h7 && $fell(sleep)
        |-> fetch_resume ##1 !fetch_resume) else $error("Resume pulse wrong");
    chk_no_idle_wake: assert property (fetch_resume |-> $past(sleep))
        else $error("Resume while awake");
    chk_vector_ack: assert property (INTERRUPT_MODE == 2 && int_taken
        |=> interrupt_ack && int_vector == $past(interrupt_address)) else $error("Vector ack wrong");
    chk_core_clear: assert property ($rose(core_reset || core_reset_alt)
        |-> ##[3:4] (!halt_req && !missed_exception_halt && !sleep) ##1 !pipeline_halted)
        else $error("Core reset did not clear");
endmodule
bind chs_core_halt_sleep_control chs_props #(.DEBUG_ENABLED(DEBUG_ENABLED), .FAULT_TOLERANT(FAULT_TOLERANT),
    .INTERRUPT_MODE(INTERRUPT_MODE)) u_props (.*);
`default_nettype wire

// File: sim/tb_chs_core_halt_sleep_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "chs_map.vh"
module tb_chs_core_halt_sleep_control;
    reg         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, core_reset = 1'b0, core_reset_alt = 1'b0;
    reg         missed_exception = 1'b0, sleep_exec = 1'b0, ext_access_busy = 1'b0, pipe_stopped = 1'b0;
    reg         int_taken = 1'b0, stop_go = 1'b0, kick = 1'b0;
    reg  [1:0]  wake_val = 2'h0;
    reg  [3:0]  s_axi_wstrb = 4'hF;
    reg  [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    reg  [31:0] s_axi_wdata = 32'h0, interrupt_address = 32'h0;
    reg  [15:0] seed = 16'd21857;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dbg_stop, halt_req;
    wire        fetch_hold, fetch_resume, pipeline_halted, missed_exception_halt, sleep, dbg_wakeup;
    wire        interrupt_ack, irq;
    wire [1:0]  s_axi_bresp, s_axi_rresp, wakeup;
    wire [31:0] s_axi_rdata, int_vector;
    integer     n_fail = 0, n_checks = 0, i, k;
    reg  [1:0]  bq[$];
    reg  [33:0] rq[$];
    chs_core_halt_sleep_control dut (.*);
    chs_partner u_partner (.*);
    always #20 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task chk(input [33:0] got, input [33:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] e);
        begin
            bq.push_back(e);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            // Request NBAs are not yet visible, so the first pass always waits an edge
            for (i = 0; i < 50 && (i == 0 || s_axi_awvalid || s_axi_wvalid || s_axi_bready); i = i + 1) begin
                @(posedge aclk);
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid) s_axi_bready <= 1'b0;
            end
            if (i == 50) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: write handshake timed out", $time);
            end
        end
    endtask
    task rd(input [7:0] a, input [33:0] e);
        begin
            rq.push_back(e);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            for (i = 0; i < 50 && (i == 0 || s_axi_arvalid || s_axi_rready); i = i + 1) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid) s_axi_rready <= 1'b0;
            end
            if (i == 50) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: read handshake timed out", $time);
            end
        end
    endtask
    // Responses are judged against the oldest expectation
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end
    task conclude;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        conclude;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(`CHS_OFF_STAT, 34'h0);
        rd(`CHS_OFF_IRQ_MASK, {2'h0, 28'h0, `CHS_RST_MASK});
        rd(8'h40, {`CHS_RESP_SLVERR, 32'h0});
        wr(8'h40, 32'h1, `CHS_RESP_SLVERR);
        wr(`CHS_OFF_IRQ_MASK, 32'hF, `CHS_RESP_OKAY);
        pipe_stopped <= 1'b1;
        stop_go <= 1'b1;
        @(posedge aclk);
        stop_go <= 1'b0;
        for (i = 0; i < 10 && pipeline_halted !== 1'b1; i = i + 1) @(posedge aclk);
        chk({33'h0, pipeline_halted}, 34'h1);
        rd(`CHS_OFF_STAT, 34'h9);
        chk({33'h0, irq}, 34'h1);
        wr(`CHS_OFF_IRQ_STAT, 32'h1, `CHS_RESP_OKAY);
        chk({33'h0, irq}, 34'h0);
        wr(`CHS_OFF_CTRL, 32'h2, `CHS_RESP_OKAY);
        rd(`CHS_OFF_STAT, 34'h0);
        missed_exception <= 1'b1;
        @(posedge aclk);
        missed_exception <= 1'b0;
        // Halted output trails the halt request by one edge
        @(posedge aclk);
        rd(`CHS_OFF_STAT, 34'hB);
        wr(`CHS_OFF_CTRL, 32'h2, `CHS_RESP_OKAY);
        rd(`CHS_OFF_STAT, 34'hB);
        core_reset_alt <= 1'b1;
        repeat (3) @(posedge aclk);
        core_reset_alt <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`CHS_OFF_STAT, 34'h0);
        wr(`CHS_OFF_CTRL, 32'h1, `CHS_RESP_OKAY);
        rd(`CHS_OFF_STAT, 34'h9);
        core_reset <= 1'b1;
        repeat (3) @(posedge aclk);
        core_reset <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(`CHS_OFF_STAT, 34'h0);
        wr(`CHS_OFF_IRQ_STAT, 32'hF, `CHS_RESP_OKAY);
        chk({33'h0, irq}, 34'h0);
        for (k = 1; k < 4; k = k + 1) begin
            wake_val <= k[1:0];
            kick <= 1'b1;
            repeat (4) @(posedge aclk);
            kick <= 1'b0;
            ext_access_busy <= 1'b1;
            sleep_exec <= 1'b1;
            @(posedge aclk);
            sleep_exec <= 1'b0;
            repeat (5) @(posedge aclk);
            chk({33'h0, sleep}, 34'h0);
            ext_access_busy <= 1'b0;
            repeat (3) @(posedge aclk);
            chk({33'h0, sleep}, 34'h1);
            if (k == 3) wr(`CHS_OFF_CTRL, 32'h4, `CHS_RESP_OKAY);
            else kick <= 1'b1;
            for (i = 0; i < 10 && sleep !== 1'b0; i = i + 1) @(posedge aclk);
            kick <= 1'b0;
            chk({33'h0, sleep}, 34'h0);
        end
        for (k = 0; k < 4; k = k + 1) begin
            seed = lfsr(seed);
            interrupt_address <= {seed, ~seed};
            int_taken <= 1'b1;
            @(posedge aclk);
            int_taken <= 1'b0;
            @(negedge aclk);
            chk({1'b0, interrupt_ack, int_vector}, {2'h1, seed, ~seed});
            @(posedge aclk);
            rd(`CHS_OFF_VECTOR, {2'h0, seed, ~seed});
        end
        repeat (3) @(posedge aclk);
        conclude;
    end
endmodule
`default_nettype wire
